//--- motdet_host.sv
// Two-wire bus host model that reads and writes the detector's registers.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module motdet_host #(
  parameter logic [6:0] DEV = 7'h2A  // Arbitrary bus address.
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // The bus rests released, clock high, outside frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Five core cycles per half bit give the 80 ns link period.
  task automatic half;
    repeat (5) @(posedge clk);
    #1;
  endtask : half
  // Data changes two cycles after the clock fall and three before the
  // rise, so it never races either edge; a bit lasts ten core cycles.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    repeat (3) @(posedge clk);
    #1;
    scl = 1'b1;
    half;
    r = sda;
    scl = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : bit_io
  // Start, also used as repeated start from a low clock.
  task automatic start;
    sda_low = 1'b0;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b1;
    half;
    scl = 1'b0;
    half;
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    half;
    scl = 1'b1;
    half;
    sda_low = 1'b0;
    half;
  endtask : stop
  // Byte out MSB first, then the device's acknowledge bit.
  task automatic tx(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
  endtask : tx
  task automatic wr(input logic [7:0] a, input logic [7:0] b);
    start;
    tx({DEV, 1'b0});
    tx(a);
    tx(b);
    stop;
  endtask : wr
  // Single byte read, closed by a not-acknowledge and a stop.
  task automatic rd(input logic [7:0] a, output logic [7:0] b);
    logic r;
    start;
    tx({DEV, 1'b0});
    tx(a);
    start;
    tx({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(1'b1, r);
    stop;
  endtask : rd
endmodule : motdet_host

//--- motdet_pkg.sv
// Constants and types shared by the motion event detector.
// Assumes a 125 MHz core clock and 6-bit two's complement axis results.
package motdet_pkg;

  // Clock and sample timing.
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CYC_PER_US    = 1000 / CLK_PERIOD_NS;
  localparam int unsigned OVERSAMPLE    = 32;
  localparam int unsigned OVS_SHIFT     = 5;

  // Measurement interval per rate code, in microseconds.
  localparam int unsigned IVL_US_0 = 8360;
  localparam int unsigned IVL_US_1 = 15625;
  localparam int unsigned IVL_US_2 = 31250;
  localparam int unsigned IVL_US_3 = 62500;
  localparam int unsigned IVL_US_4 = 125000;
  localparam int unsigned IVL_US_5 = 250000;
  localparam int unsigned IVL_US_6 = 500000;
  localparam int unsigned IVL_US_7 = 1000000;

  // Register indices.
  localparam logic [7:0] REG_X    = 8'h00;
  localparam logic [7:0] REG_Y    = 8'h01;
  localparam logic [7:0] REG_Z    = 8'h02;
  localparam logic [7:0] REG_TILT = 8'h03;
  localparam logic [7:0] REG_EN   = 8'h06;
  localparam logic [7:0] REG_MODE = 8'h07;
  localparam logic [7:0] REG_RATE = 8'h08;
  localparam logic [7:0] REG_TAP  = 8'h09;
  localparam logic [7:0] REG_DUR  = 8'h0A;

  // Field positions.
  localparam int unsigned EN_SHX = 7;
  localparam int unsigned EN_SHY = 6;
  localparam int unsigned EN_SHZ = 5;
  localparam int unsigned EN_GEN = 4;
  localparam int unsigned EN_TAP = 2;
  localparam int unsigned EN_PL  = 1;
  localparam int unsigned EN_BF  = 0;
  localparam int unsigned MODE_ACT = 0;
  localparam int unsigned MODE_TST = 2;

  // Thresholds in result counts, at about 21 counts per g.
  localparam logic [5:0] SHAKE_CNT = 6'h1B;
  localparam logic [5:0] FLAT_CNT  = 6'h10;
  localparam logic [5:0] BF_CNT    = 6'h05;

  // Orientation codes.
  localparam logic [2:0] PL_UNKNOWN = 3'h0;
  localparam logic [2:0] PL_LEFT    = 3'h1;
  localparam logic [2:0] PL_RIGHT   = 3'h2;
  localparam logic [2:0] PL_DOWN    = 3'h5;
  localparam logic [2:0] PL_UP      = 3'h6;
  localparam logic [1:0] BF_UNKNOWN = 2'h0;
  localparam logic [1:0] BF_FRONT   = 2'h1;
  localparam logic [1:0] BF_BACK    = 2'h2;

  // Two-wire slave states.
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_ADDR = 3'b001,
    MD_AACK = 3'b010,
    MD_WBYT = 3'b011,
    MD_WACK = 3'b100,
    MD_RBYT = 3'b101,
    MD_RACK = 3'b110
  } motdet_i2c_type;

  localparam logic [3:0] BITS_DONE = 4'h8;

endpackage : motdet_pkg

//--- motdet_top.sv
// Motion event detector: two-wire register slave, averaging, orientation,
// shake and tap analysis. Assumes the front end delivers readings on the
// core clock and that the bus pins are external and asynchronous.
`timescale 1ns/1ps
module motdet_top
  import motdet_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR   = 7'h2A,      // Arbitrary bus address.
  parameter int unsigned CYC_US     = CYC_PER_US  // Shorten for simulation.
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              adc_valid,
  input  wire logic signed [5:0] adc_x,
  input  wire logic signed [5:0] adc_y,
  input  wire logic signed [5:0] adc_z,
  output logic                   measure_en,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Magnitude of a 6-bit result, saturating -32 to 31 is not needed.
  function automatic logic [5:0] mag(input logic [5:0] v);
    mag = v[5] ? 6'(~v + 6'h01) : v;
  endfunction : mag

  // Interval length in core cycles for a rate code.
  function automatic logic [31:0] ivl(input logic [2:0] c);
    int unsigned us;
    unique case (c)
      3'h0: us = IVL_US_0;
      3'h1: us = IVL_US_1;
      3'h2: us = IVL_US_2;
      3'h3: us = IVL_US_3;
      3'h4: us = IVL_US_4;
      3'h5: us = IVL_US_5;
      3'h6: us = IVL_US_6;
      3'h7: us = IVL_US_7;
    endcase
    ivl = 32'(us * CYC_US);
  endfunction : ivl

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and the history flop feed logic.

  logic scl_m_q, scl_s_q, scl_p_q;  // Clock pin stages and history.
  logic sda_m_q, sda_s_q, sda_p_q;  // Data pin stages and history.

  // Two flops per pin, then one history flop for edge finding.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  ////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [5:0] res_q [3];      // Axis results x, y, z.
  logic       shake_q;        // Shared shake flag.
  logic       tap_q;          // Tap flag; also disarms detection.
  logic [2:0] portrait_landscape_code_q;         // Committed portrait/landscape code.
  logic [1:0] back_front_code_q;        // Committed back/front code.
  logic [7:0] en_q;           // Event enables.
  logic [7:0] mode_q;         // Mode register.
  logic [7:0] rate_q;         // Debounce depth and rate select.
  logic [7:0] tapcfg_q;       // Tap axes and threshold.
  logic [7:0] dur_q;          // Tap duration count.

  wire [2:0] rate_sel = rate_q[2:0];
  wire [2:0] deb_dep  = rate_q[7:5];
  wire [2:0] tap_axes = {tapcfg_q[7], tapcfg_q[6], tapcfg_q[5]};  // z,y,x.
  wire [4:0] tap_thr  = tapcfg_q[4:0];
  wire       standby  = ~mode_q[MODE_ACT];
  wire       test_md  = mode_q[MODE_TST];
  wire       active   = mode_q[MODE_ACT] & ~test_md;

  ////////////////////////////////////////////////////////////////////////
  // Two-wire slave.

  motdet_i2c_type st_q;
  logic [7:0] sh_q;     // Receive shift register.
  logic [7:0] tx_q;     // Transmit shift register.
  logic [3:0] bit_q;    // Bits moved in the current byte.
  logic       rw_q;     // Transfer direction, high for read.
  logic       first_q;  // Next written byte is the pointer.
  logic       nack_q;   // Master declined further data.
  logic [7:0] ptr_q;    // Register pointer.
  logic       oe_q;     // Data pin pulled low.
  logic       sdo_q;    // Driven level; low whenever enabled.
  logic       trd_q;    // One-cycle status read pulse.
  logic       wr_q;     // One-cycle register write pulse.
  logic [7:0] wdat_q;   // Data of that write.
  logic [7:0] wadr_q;   // Address of that write.

  // Read data selection for the current pointer.
  wire [7:0] tilt_byte = {shake_q, 1'b0, tap_q, portrait_landscape_code_q, back_front_code_q};
  wire [7:0] rd_data =
    (ptr_q == REG_X)    ? {2'h0, res_q[0]} :
    (ptr_q == REG_Y)    ? {2'h0, res_q[1]} :
    (ptr_q == REG_Z)    ? {2'h0, res_q[2]} :
    (ptr_q == REG_TILT) ? tilt_byte :
    (ptr_q == REG_EN)   ? en_q :
    (ptr_q == REG_MODE) ? mode_q :
    (ptr_q == REG_RATE) ? rate_q :
    (ptr_q == REG_TAP)  ? tapcfg_q :
    (ptr_q == REG_DUR)  ? dur_q : 8'h00;

  wire addr_hit  = (sh_q[7:1] == DEV_ADDR);
  wire byte_done = (bit_q == BITS_DONE);

  // Bus state machine; samples on rising clock, drives on falling clock.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= MD_IDLE;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
      sdo_q <= 1'b0;
      trd_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= 8'h00;
      wadr_q <= 8'h00;
    end else begin
      trd_q <= 1'b0;
      wr_q <= 1'b0;
      if (bus_stop) begin
        // A stop frees the bus whatever the state.
        st_q <= MD_IDLE;
        oe_q <= 1'b0;
      end else if (bus_start) begin
        // A start, repeated or not, begins an address byte.
        st_q <= MD_ADDR;
        bit_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == MD_ADDR || st_q == MD_WBYT) begin
          sh_q <= {sh_q[6:0], sda_s_q};
          bit_q <= 4'(bit_q + 4'h1);
        end else if (st_q == MD_RBYT) begin
          bit_q <= 4'(bit_q + 4'h1);
        end else if (st_q == MD_RACK) begin
          // Master acknowledge bit of a read byte.
          nack_q <= sda_s_q;
          trd_q <= (ptr_q == REG_TILT);
          ptr_q <= 8'(ptr_q + 8'h01);
        end
      end else if (scl_fall) begin
        unique case (st_q)
          MD_IDLE: st_q <= MD_IDLE;
          MD_ADDR: begin
            if (byte_done) begin
              st_q <= addr_hit ? MD_AACK : MD_IDLE;
              oe_q <= addr_hit;
              rw_q <= sh_q[0];
              first_q <= 1'b1;
            end
          end
          MD_AACK, MD_RACK: begin
            bit_q <= 4'h0;
            if (rw_q && !(st_q == MD_RACK && nack_q)) begin
              st_q <= MD_RBYT;
              oe_q <= ~rd_data[7];
              tx_q <= {rd_data[6:0], 1'b0};
            end else begin
              st_q <= (st_q == MD_AACK) ? MD_WBYT : MD_IDLE;
              oe_q <= 1'b0;
            end
          end
          MD_WBYT: begin
            if (byte_done) begin
              st_q <= MD_WACK;
              oe_q <= 1'b1;
              first_q <= 1'b0;
              if (first_q) begin
                ptr_q <= sh_q;
              end else begin
                wr_q <= 1'b1;
                wadr_q <= ptr_q;
                wdat_q <= sh_q;
                ptr_q <= 8'(ptr_q + 8'h01);
              end
            end
          end
          MD_WACK: begin
            st_q <= MD_WBYT;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
          end
          MD_RBYT: begin
            if (byte_done) begin
              st_q <= MD_RACK;
              oe_q <= 1'b0;
            end else begin
              oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          default: st_q <= MD_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration writes. Settings other than mode only take while in
  // standby, so a running analysis never sees a torn configuration.

  wire cfg_ok  = wr_q & standby;
  wire tst_wr  = wr_q & test_md & (wadr_q <= REG_Z);

  // Writable register file.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= 8'h00;
      mode_q <= 8'h00;
      rate_q <= 8'h00;
      tapcfg_q <= 8'h00;
      dur_q <= 8'h00;
    end else begin
      if (wr_q && wadr_q == REG_MODE) mode_q <= wdat_q;
      if (cfg_ok && wadr_q == REG_EN) en_q <= wdat_q;
      if (cfg_ok && wadr_q == REG_RATE) rate_q <= wdat_q;
      if (cfg_ok && wadr_q == REG_TAP) tapcfg_q <= wdat_q;
      if (cfg_ok && wadr_q == REG_DUR) dur_q <= wdat_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interval timer and 32-reading average.

  logic [31:0] ivl_q;              // Cycles into the current interval.
  logic        cap_q;              // Collecting oversampled readings.
  logic [5:0]  ncap_q;             // Readings collected.
  logic signed [10:0] sum_q [3];   // Running sums.
  logic        upd_q;              // New results are in place.

  wire ivl_end  = active & (ivl_q >= 32'(ivl(rate_sel) - 32'h1));
  wire cap_last = cap_q & adc_valid & (ncap_q == 6'(OVERSAMPLE - 1));
  wire signed [5:0] adc_v [3] = '{adc_x, adc_y, adc_z};

  // Interval counter; held clear outside active measurement.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ivl_q <= 32'h0;
    else if (!active || ivl_end) ivl_q <= 32'h0;
    else ivl_q <= 32'(ivl_q + 32'h1);
  end

  // Capture: 32 readings summed, then the mean is stored.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cap_q <= 1'b0;
      ncap_q <= 6'h00;
      sum_q <= '{3{11'sh000}};
      res_q <= '{3{6'h00}};
      upd_q <= 1'b0;
    end else begin
      upd_q <= cap_last | tst_wr;
      if (!active) begin
        cap_q <= 1'b0;
      end else if (ivl_end && !cap_q) begin
        cap_q <= 1'b1;
        ncap_q <= 6'h00;
        sum_q <= '{3{11'sh000}};
      end else if (cap_q && adc_valid) begin
        ncap_q <= 6'(ncap_q + 6'h01);
        cap_q <= ~cap_last;
        for (int i = 0; i < 3; i++) begin
          sum_q[i] <= 11'(sum_q[i] + 11'(adc_v[i]));
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (cap_last) begin
          // The last reading joins the sum as the mean is taken.
          res_q[i] <= 6'((sum_q[i] + 11'(adc_v[i])) >>> OVS_SHIFT);
        end else if (tst_wr && wadr_q == 8'(i)) begin
          res_q[i] <= wdat_q[5:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Orientation candidate and debounce.

  wire [5:0] ax = mag(res_q[0]);
  wire [5:0] ay = mag(res_q[1]);
  wire [5:0] az = mag(res_q[2]);
  wire       flat = az < FLAT_CNT;
  wire [2:0] cand_pl =
    (flat && ax > ay) ? (res_q[0][5] ? PL_UP : PL_DOWN) :
    (flat && ay > ax) ? (res_q[1][5] ? PL_RIGHT : PL_LEFT) :
    PL_UNKNOWN;
  wire signed [5:0] zs = res_q[2];
  wire [1:0] cand_bf =
    (zs < -$signed(BF_CNT)) ? BF_BACK :
    (zs > $signed(BF_CNT))  ? BF_FRONT : BF_UNKNOWN;

  logic [4:0] prev_q;   // Previous candidate.
  logic [2:0] deb_q;    // Consecutive matching readings.

  wire match    = ({cand_pl, cand_bf} == prev_q);
  wire [2:0] deb_nxt = match ? 3'(deb_q + 3'h1) : 3'h0;
  wire commit   = upd_q & ((deb_dep == 3'h0) ||
                           (match && deb_nxt >= deb_dep));
  wire ori_chg  = commit & ({cand_pl, cand_bf} != {portrait_landscape_code_q, back_front_code_q});

  // Debounce state and committed codes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 5'h00;
      deb_q <= 3'h0;
      portrait_landscape_code_q <= PL_UNKNOWN;
      back_front_code_q <= BF_UNKNOWN;
    end else if (upd_q) begin
      prev_q <= {cand_pl, cand_bf};
      deb_q <= commit ? 3'h0 : deb_nxt;
      if (commit) begin
        portrait_landscape_code_q <= cand_pl;
        back_front_code_q <= cand_bf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shake and tap.

  wire [2:0] sh_en = {en_q[EN_SHZ], en_q[EN_SHY], en_q[EN_SHX]};
  wire [2:0] sh_ax = {az > SHAKE_CNT, ay > SHAKE_CNT, ax > SHAKE_CNT};
  wire shake_hit = upd_q & |(sh_en & sh_ax);

  logic [5:0] last_q [3];  // Results of the previous sample.
  logic [7:0] tcnt_q;      // Consecutive over-threshold samples.
  logic       tprim_q;     // A previous sample exists for deltas.

  // Per-axis change since the previous sample, against the threshold.
  wire [2:0] t_over;
  for (genvar g = 0; g < 3; g++) begin : g_delta
    wire [6:0] dlt = 7'({res_q[g][5], res_q[g]} - {last_q[g][5], last_q[g]});
    wire [6:0] dmag = dlt[6] ? 7'(~dlt + 7'h01) : dlt;
    assign t_over[g] = (dmag > {2'b00, tap_thr});
  end
  // Taps need the fastest rate unless all axes run delta-G.
  wire t_rate  = (rate_sel == 3'h0) | (&tap_axes);
  wire t_armed = en_q[EN_TAP] & ~tap_q & t_rate & tprim_q;
  wire t_seen  = |(tap_axes & t_over);
  wire tap_hit = upd_q & t_armed & t_seen & (tcnt_q >= dur_q);

  // Shared status flags; a new event wins over a clearing read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shake_q <= 1'b0;
      tap_q <= 1'b0;
      tcnt_q <= 8'h00;
      tprim_q <= 1'b0;
      last_q <= '{3{6'h00}};
    end else begin
      if (shake_hit) shake_q <= 1'b1;
      else if (trd_q) shake_q <= 1'b0;
      if (tap_hit) tap_q <= 1'b1;
      else if (trd_q) tap_q <= 1'b0;
      if (upd_q) begin
        last_q <= res_q;
        tprim_q <= 1'b1;
        if (!t_armed || !t_seen || tap_hit) tcnt_q <= 8'h00;
        else if (tcnt_q != 8'hFF) tcnt_q <= 8'(tcnt_q + 8'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin and outputs.

  wire ori_irq = ori_chg & (en_q[EN_PL] | en_q[EN_BF]);
  wire irq_set = ori_irq | (shake_hit) | (tap_hit) |
                 (upd_q & en_q[EN_GEN]);
  logic irq_q;   // Interrupt level, held until the status read.
  logic meas_q;  // Front end request level.

  // Interrupt holds until the status read; a new event wins.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      meas_q <= 1'b0;
    end else begin
      irq_q <= irq_set | (irq_q & ~trd_q);
      meas_q <= active & (cap_q | ivl_end);
    end
  end

  assign irq = irq_q;
  assign measure_en = meas_q;
  assign sda_oe = oe_q;
  assign sda_o = sdo_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  a_debounce_depth_zero_commit: assert property (@(posedge clk) disable iff (!resetn)
    upd_q && deb_dep == 3'h0 |=> portrait_landscape_code_q == $past(cand_pl))
    else $error("orientation not committed at zero depth");
  a_deb_mismatch_clr: assert property (@(posedge clk) disable iff (!resetn)
    upd_q && !match |=> deb_q == 3'h0)
    else $error("debounce count kept after mismatch");
  a_deb_bound_hold: assert property (@(posedge clk) disable iff (!resetn)
    upd_q && deb_dep != 3'h0 && !match |=> $stable(portrait_landscape_code_q))
    else $error("orientation changed on mismatched reading");
  a_shake_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    shake_hit |=> shake_q && irq_q)
    else $error("shake not flagged");
  a_shake_read_clear: assert property (@(posedge clk) disable iff (!resetn)
    trd_q && !shake_hit |=> !shake_q)
    else $error("shake kept after status read");
  a_tap_hold_set: assert property (@(posedge clk) disable iff (!resetn)
    tap_q && !trd_q |=> tap_q ##0 !tap_hit)
    else $error("tap flag lost or detection active");
  a_standby_no_meas: assert property (@(posedge clk) disable iff (!resetn)
    !active [*2] |-> !cap_q && !meas_q)
    else $error("measurement while inactive");
  a_avg_store_res: assert property (@(posedge clk) disable iff (!resetn)
    cap_last |=> upd_q && res_q[0] ==
      6'(($past(sum_q[0]) + 11'($past(adc_x))) >>> OVS_SHIFT))
    else $error("average not stored");
  a_read_pulse_one: assert property (@(posedge clk) disable iff (!resetn)
    trd_q |=> !trd_q)
    else $error("status read pulse too long");
  a_gen_irq_sets: assert property (@(posedge clk) disable iff (!resetn)
    upd_q && en_q[EN_GEN] |=> irq_q)
    else $error("data update interrupt missing");

  c_tap_seen:   cover property (@(posedge clk) tap_hit);
  c_shake_seen: cover property (@(posedge clk) shake_hit);
  c_deb_commit: cover property (@(posedge clk) commit && deb_dep != 3'h0);
  c_tilt_read:  cover property (@(posedge clk) trd_q);

endmodule : motdet_top

//--- tb_motion_event_detector.sv
// Self-checking bench: host model traffic compared with an integer model.
// Assumes the design runs with one cycle per microsecond of interval.
`timescale 1ns/1ps
module tb_motion_event_detector;
  import motdet_pkg::*;
  logic clk, resetn, adc_valid, scl, host_low, sda_o, sda_oe;
  logic measure_en, irq, shake = 1'b0, tap = 1'b0, irq_m = 1'b0;
  logic prim = 1'b0;
  logic signed [5:0] adc_x, adc_y, adc_z;
  // Open-drain data line: whoever pulls low wins, else the pull-up.
  wire logic sda = host_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  int seed = 55778, n_fail = 0, n_tests = 0, cyc = 0, t0, k, s[3];
  int mx = 0, my = 0, mz = 0, px, py, pz, cnt = 0, tc = 0, dur = 0;
  logic [7:0] en = 8'h00, d;
  logic [4:0] thr = 5'h00, cur = 5'h00, pc = 5'h00;
  logic [2:0] debounce_depth = 3'h0, tax = 3'h0;
  motdet_top #(.CYC_US(1)) motdet_top_inst (.clk(clk), .resetn(resetn),
    .scl_in(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .adc_valid(adc_valid), .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z),
    .measure_en(measure_en), .irq(irq));
  motdet_host motdet_host_inst (.clk(clk), .sda(sda), .scl(scl),
    .sda_low(host_low));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hung handshake ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(string nm, logic [7:0] a, logic [7:0] e);
    motdet_host_inst.rd(a, d);
    chk(nm, e, d);
  endtask : rdchk
  function automatic int mag(int v);
    return v < 0 ? -v : v;
  endfunction : mag
  // Reference analysis of one reading, run after every result write.
  task automatic analyze;
    logic [4:0] c;
    logic seen, armed;
    c[1:0] = mz < -5 ? BF_BACK : mz > 5 ? BF_FRONT : BF_UNKNOWN;
    c[4:2] = (mag(mz) >= 16 || mag(mx) == mag(my)) ? PL_UNKNOWN :
      mag(mx) > mag(my) ? (mx < 0 ? PL_UP : PL_DOWN) :
      (my < 0 ? PL_RIGHT : PL_LEFT);
    if ((en[7] && mag(mx) > 27) || (en[6] && mag(my) > 27) ||
        (en[5] && mag(mz) > 27)) {shake, irq_m} = 2'b11;
    seen = (tax[0] && mag(mx - px) > thr) || (tax[1] && mag(my - py) > thr)
      || (tax[2] && mag(mz - pz) > thr);
    // The very first sample has no predecessor, so it cannot be a tap.
    armed = en[2] && !tap && prim;
    // A tap needs dur earlier over-threshold samples in a row.
    if (armed && seen && tc >= dur) {tap, irq_m} = 2'b11;
    tc = (!armed || !seen || tap) ? 0 : tc + 1;
    prim = 1'b1;
    cnt = (c == pc) ? cnt + 1 : 0;
    pc = c;
    // Depth zero commits at once; otherwise after that many matches.
    if (debounce_depth == 3'h0 || cnt >= debounce_depth) begin
      if (c != cur && en[1:0] != 2'h0) irq_m = 1'b1;
      cur = c;
      cnt = 0;
    end
  endtask : analyze
  task automatic wr(logic [7:0] a, logic [7:0] v);
    motdet_host_inst.wr(a, v);
    {px, py, pz} = {mx, my, mz};
    case (a)
      REG_X: mx = $signed(v[5:0]);
      REG_Y: my = $signed(v[5:0]);
      REG_Z: mz = $signed(v[5:0]);
      REG_EN: en = v;
      REG_RATE: debounce_depth = v[7:5];
      REG_TAP: {tax, thr} = v;
      REG_DUR: dur = v;
      default: ;
    endcase
    if (a < 8'h03) analyze;
  endtask : wr
  // Status read: compares, then shake, tap and interrupt must be gone.
  task automatic tilt;
    rdchk("orientation_status", REG_TILT, {shake, 1'b0, tap, cur});
    {shake, tap, irq_m} = 3'b000;
    chk("irq after read", 0, irq);
  endtask : tilt
  initial begin
    {resetn, adc_valid, adc_x, adc_y, adc_z} = '0;
    repeat (6) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) tick;
    rdchk("x_axis_result", REG_X, 8'h00);
    rdchk("unmapped", 8'h0B, 8'h00);
    wr(REG_MODE, 8'h04);
    wr(REG_DUR, 8'h01);
    repeat (12) begin
      wr(REG_EN, 8'($random(seed)) & 8'hE7);
      wr(REG_RATE, {3'($random(seed)), 5'h00});
      wr(REG_TAP, 8'($random(seed)));
      for (int i = 0; i < 3; i++) wr(8'(i), 8'($random(seed)));
      chk("measure_en", 0, measure_en);
      chk("irq", irq_m, irq);
      rdchk("x_axis_result", REG_X, {2'b00, 6'(mx)});
      tilt;
    end
    wr(REG_RATE, 8'h60);
    wr(REG_Y, 8'h00);
    wr(REG_Z, 8'h00);
    repeat (5) begin
      wr(REG_X, 8'h2C);
      tilt;
    end
    wr(REG_MODE, 8'h00);
    wr(REG_EN, 8'h10);
    wr(REG_RATE, 8'h00);
    tilt;
    wr(REG_MODE, 8'h01);
    for (k = 0; k < 9000 && !measure_en; k++) tick;
    t0 = cyc;
    s = '{0, 0, 0};
    repeat (32) begin
      {adc_x, adc_y, adc_z} = 18'($random(seed));
      adc_valid = 1'b1;
      s[0] += adc_x;
      s[1] += adc_y;
      s[2] += adc_z;
      tick;
      adc_valid = 1'b0;
      tick;
    end
    for (k = 0; k < 10 && !irq; k++) tick;
    chk("irq on data update", 1, irq);
    for (int i = 0; i < 3; i++)
      rdchk("axis mean", 8'(i), {2'b00, 6'(s[i] >>> 5)});
    for (k = 0; k < 9000 && !measure_en; k++) tick;
    chk("interval", IVL_US_0, 16'(cyc - t0));
    wrap_up;
  end
endmodule : tb_motion_event_detector
